// >>> src/amc_mailbox.sv
// Relationship abort and offline indications, and server configuration commands
`timescale 1ns/1ps

// Notes on behaviour
// - Abort sends 0118h, info 4002h, size zero
// - Extended word1 handle, word2 abort reason
// - Indications only when relationship info enabled
// - Reason codes span 3 through 32
// - Offline sends 0119h with handle and reason
// - Accept timeout command 0020h, size 0002h
// - Close connections idle beyond the timeout
// - Zero disables timeout; 10-65535 are seconds
// - Default connection timeout is sixty seconds
// - Timeout response echoes the data word
// - Command 0021h disables server, empty response
module amc_mailbox #(
  parameter int unsigned TICKS_PER_SEC = amc_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  // Configuration
  input  wire logic [15:0]                         advanced_mode_config_word,
  input  wire logic                                init_done,
  // Relationship events
  input  wire logic                                abort_event,
  input  wire logic [15:0]                         abort_handle,
  input  wire logic [15:0]                         abort_reason,
  input  wire logic                                offline_event,
  input  wire logic [15:0]                         offline_handle,
  input  wire logic [15:0]                         offline_reason,
  // Indication messages to the host
  output logic                                     ind_valid,
  input  wire logic                                ind_ready,
  output logic [15:0]                              ind_id,
  output logic [15:0]                              ind_info,
  output logic [15:0]                              ind_cmd,
  output logic [15:0]                              ind_size,
  output logic [amc_pkg::EXT_WORDS-1:0][15:0]      ind_ext,
  // Commands from the host
  input  wire logic                                cmd_valid,
  output logic                                     cmd_ready,
  input  wire logic [15:0]                         cmd_id,
  input  wire logic [15:0]                         cmd_code,
  input  wire logic [15:0]                         cmd_size,
  input  wire logic [15:0]                         cmd_data,
  // Responses to the host
  output logic                                     rsp_valid,
  input  wire logic                                rsp_ready,
  output logic [15:0]                              rsp_id,
  output logic [15:0]                              rsp_info,
  output logic [15:0]                              rsp_code,
  output logic [15:0]                              rsp_size,
  output logic [15:0]                              rsp_data,
  // Server connection
  output logic                                     server_enable,
  output logic [15:0]                              timeout_value,
  input  wire logic                                conn_open,
  input  wire logic                                conn_request,
  output logic                                     conn_close
);
  import amc_pkg::*;

  amc_srv_if srv ();

  amc_ind_state_t             ind_state_q;
  logic                       rel_info_en;
  logic                       abort_ok;
  logic                       offline_ok;
  logic                       abort_pend_q;
  logic [15:0]                abort_h_q;
  logic [15:0]                abort_r_q;
  logic                       offline_pend_q;
  logic [15:0]                offline_h_q;
  logic [15:0]                offline_r_q;
  logic                       load_abort;
  logic                       load_offline;
  logic                       ind_valid_q;
  logic [15:0]                ind_id_q;
  logic [15:0]                msg_id_q;
  logic [15:0]                ind_cmd_q;
  logic [EXT_WORDS-1:0][15:0] ind_ext_q;
  logic                       cmd_take;
  logic                       cmd_ready_q;
  logic                       rsp_valid_q;
  logic [15:0]                rsp_id_q;
  logic [15:0]                rsp_info_q;
  logic [15:0]                rsp_code_q;
  logic [15:0]                rsp_size_q;
  logic [15:0]                rsp_data_q;
  logic                       dec_err;
  logic                       dec_set_timeout;
  logic                       dec_disable;
  logic [15:0]                dec_size;
  logic [15:0]                dec_data;
  logic [15:0]                timeout_q;
  logic                       server_en_q;

  // Event qualification
  assign rel_info_en = advanced_mode_config_word[ADV_REL_INFO_BIT];
  // Out-of-range reasons are dropped rather than sent as a code the host cannot decode
  assign abort_ok    = abort_event && rel_info_en &&
                       abort_reason >= REASON_MIN && abort_reason <= REASON_MAX;
  assign offline_ok  = offline_event && rel_info_en &&
                       offline_reason >= REASON_MIN && offline_reason <= REASON_MAX;

  // Abort has priority when both are waiting
  assign load_abort   = (ind_state_q == AMC_IND_IDLE) && abort_pend_q;
  assign load_offline = (ind_state_q == AMC_IND_IDLE) && !abort_pend_q && offline_pend_q;

  // One pending slot per kind; a fresh event in the load cycle wins over the clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      abort_pend_q <= 1'b0;
      abort_h_q    <= WORD_ZERO;
      abort_r_q    <= WORD_ZERO;
    end else if (abort_ok) begin
      abort_pend_q <= 1'b1;
      abort_h_q    <= abort_handle;
      abort_r_q    <= abort_reason;
    end else if (load_abort) begin
      abort_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      offline_pend_q <= 1'b0;
      offline_h_q    <= WORD_ZERO;
      offline_r_q    <= WORD_ZERO;
    end else if (offline_ok) begin
      offline_pend_q <= 1'b1;
      offline_h_q    <= offline_handle;
      offline_r_q    <= offline_reason;
    end else if (load_offline) begin
      offline_pend_q <= 1'b0;
    end
  end

  // Indication sender; no answer is awaited after the hand-off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_state_q <= AMC_IND_IDLE;
      ind_valid_q <= 1'b0;
      ind_id_q    <= MSG_ID_RESET;
      msg_id_q    <= MSG_ID_RESET;
      ind_cmd_q   <= WORD_ZERO;
      ind_ext_q   <= '0;
    end else begin
      case (ind_state_q)
        AMC_IND_IDLE: begin
          if (load_abort || load_offline) begin
            ind_state_q <= AMC_IND_SEND;
            ind_valid_q <= 1'b1;
            ind_id_q    <= msg_id_q;
            msg_id_q    <= msg_id_q + 16'h0001;
            for (int i = 0; i < EXT_WORDS; i++) begin
              ind_ext_q[i] <= EXT_UNUSED;
            end
            if (load_abort) begin
              ind_cmd_q                 <= CMD_REL_ABORT_IND;
              ind_ext_q[EXT_HANDLE_IDX] <= abort_h_q;
              ind_ext_q[EXT_REASON_IDX] <= abort_r_q;
            end else begin
              ind_cmd_q                 <= CMD_REL_OFFLINE_IND;
              ind_ext_q[EXT_HANDLE_IDX] <= offline_h_q;
              ind_ext_q[EXT_REASON_IDX] <= offline_r_q;
            end
          end
        end
        AMC_IND_SEND: begin
          if (ind_ready) begin
            ind_state_q <= AMC_IND_IDLE;
            ind_valid_q <= 1'b0;
          end
        end
        default: begin
          ind_state_q <= AMC_IND_IDLE;
          ind_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Command decode
  assign cmd_take = cmd_valid && cmd_ready_q;

  always_comb begin
    dec_err         = 1'b1;
    dec_set_timeout = 1'b0;
    dec_disable     = 1'b0;
    dec_size        = SIZE_NONE;
    dec_data        = WORD_ZERO;
    case (cmd_code)
      CMD_CONN_TIMEOUT: begin
        dec_size = SIZE_TIMEOUT;
        dec_data = cmd_data;
        // Late or short-timeout commands are refused, nothing is applied
        dec_err  = init_done || (cmd_size != SIZE_TIMEOUT) ||
                   (cmd_data != TIMEOUT_OFF && cmd_data < TIMEOUT_MIN_S);
        dec_set_timeout = !dec_err;
      end
      CMD_SERVER_DISABLE: begin
        dec_err     = init_done || (cmd_size != SIZE_NONE);
        dec_disable = !dec_err;
      end
      default: begin
        dec_err = 1'b1;
      end
    endcase
  end

  // Configuration state applied by accepted commands
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_q <= TIMEOUT_DEFAULT_S;
    end else if (cmd_take && dec_set_timeout) begin
      timeout_q <= cmd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      server_en_q <= 1'b1;
    end else if (cmd_take && dec_disable) begin
      server_en_q <= 1'b0;
    end
  end

  // One command in flight: the next is taken only after the response leaves
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_id_q    <= WORD_ZERO;
      rsp_info_q  <= WORD_ZERO;
      rsp_code_q  <= WORD_ZERO;
      rsp_size_q  <= WORD_ZERO;
      rsp_data_q  <= WORD_ZERO;
    end else if (cmd_take) begin
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b1;
      rsp_id_q    <= cmd_id;
      rsp_info_q  <= dec_err ? MSG_INFO_ERR : MSG_INFO_RSP;
      rsp_code_q  <= cmd_code;
      rsp_size_q  <= dec_size;
      rsp_data_q  <= dec_data;
    end else if (rsp_valid_q && rsp_ready) begin
      cmd_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
    end
  end

  // Server link to the idle timer
  assign srv.timeout_s    = timeout_q;
  assign srv.server_en    = server_en_q;
  assign srv.conn_open    = conn_open;
  assign srv.conn_request = conn_request;

  amc_conn_timer #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_conn_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .srv     (srv.timer)
  );

  // Outputs
  assign ind_valid     = ind_valid_q;
  assign ind_id        = ind_id_q;
  assign ind_info      = MSG_INFO_IND;
  assign ind_cmd       = ind_cmd_q;
  assign ind_size      = SIZE_NONE;
  assign ind_ext       = ind_ext_q;
  assign cmd_ready     = cmd_ready_q;
  assign rsp_valid     = rsp_valid_q;
  assign rsp_id        = rsp_id_q;
  assign rsp_info      = rsp_info_q;
  assign rsp_code      = rsp_code_q;
  assign rsp_size      = rsp_size_q;
  assign rsp_data      = rsp_data_q;
  assign server_enable = server_en_q;
  assign timeout_value = timeout_q;
  assign conn_close    = srv.conn_close;

endmodule // amc_mailbox

// >>> src/amc_pkg.sv
// Shared constants and types for the relationship event and server configuration mailbox
package amc_pkg;

  // Clock and one-second prescale
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SECOND_NS     = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam int          PRESCALE_W    = 28;

  // Command codes
  localparam logic [15:0] CMD_REL_ABORT_IND   = 16'h0118;
  localparam logic [15:0] CMD_REL_OFFLINE_IND = 16'h0119;
  localparam logic [15:0] CMD_CONN_TIMEOUT    = 16'h0020;
  localparam logic [15:0] CMD_SERVER_DISABLE  = 16'h0021;

  // Message information words
  localparam logic [15:0] MSG_INFO_IND = 16'h4002;
  localparam logic [15:0] MSG_INFO_RSP = 16'h0002;
  localparam logic [15:0] MSG_INFO_ERR = 16'h8002;

  // Data sizes in bytes
  localparam logic [15:0] SIZE_NONE    = 16'h0000;
  localparam logic [15:0] SIZE_TIMEOUT = 16'h0002;

  // Extended header layout
  localparam int          EXT_WORDS      = 8;
  localparam int          EXT_HANDLE_IDX = 0;
  localparam int          EXT_REASON_IDX = 1;
  localparam logic [15:0] EXT_UNUSED     = 16'h0000;

  // Advanced mode configuration word: relationship information enable bit
  localparam int ADV_REL_INFO_BIT = 0;

  // Reason code range, with one named example
  localparam logic [15:0] REASON_MIN       = 16'h0003;
  localparam logic [15:0] REASON_MAX       = 16'h0020;
  localparam logic [15:0] REASON_LINK_DOWN = 16'h001B;

  // Connection timeout in seconds
  localparam logic [15:0] TIMEOUT_OFF       = 16'h0000;
  localparam logic [15:0] TIMEOUT_MIN_S     = 16'h000A;
  localparam logic [15:0] TIMEOUT_DEFAULT_S = 16'h003C;

  // Reset values
  localparam logic [15:0] MSG_ID_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;

  typedef enum {
    AMC_IND_IDLE,
    AMC_IND_SEND
  } amc_ind_state_t;

endpackage

// >>> src/amc_srv_if.sv
// Signals between the mailbox control logic and the connection idle timer
`timescale 1ns/1ps
interface amc_srv_if;
  logic [15:0] timeout_s;
  logic        server_en;
  logic        conn_open;
  logic        conn_request;
  logic        conn_close;

  modport ctrl (
    output timeout_s,
    output server_en,
    output conn_open,
    output conn_request,
    input  conn_close
  );

  modport timer (
    input  timeout_s,
    input  server_en,
    input  conn_open,
    input  conn_request,
    output conn_close
  );
endinterface

// >>> src/amc_conn_timer.sv
// Idle timer that shuts down an established server connection
`timescale 1ns/1ps
module amc_conn_timer #(
  parameter int unsigned TICKS_PER_SEC = amc_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Timer side of the server link
  amc_srv_if.timer srv
);
  import amc_pkg::*;

  localparam logic [PRESCALE_W-1:0] PRE_LAST = PRESCALE_W'(TICKS_PER_SEC - 1);

  logic [PRESCALE_W-1:0] pre_q;
  logic [15:0]           idle_q;
  logic                  tick;
  logic                  closed_q;
  logic                  close_q;

  assign tick = (pre_q == PRE_LAST);

  // Idle seconds since the last request; a request restarts the count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q  <= '0;
      idle_q <= WORD_ZERO;
    end else if (!srv.conn_open || srv.conn_request) begin
      pre_q  <= '0;
      idle_q <= WORD_ZERO;
    end else if (tick) begin
      pre_q  <= '0;
      // Saturate so a very long idle spell cannot wrap and look fresh
      if (idle_q != '1) begin
        idle_q <= idle_q + 16'h0001;
      end
    end else begin
      pre_q <= pre_q + PRESCALE_W'(1);
    end
  end

  // One close pulse per connection; the stack drops conn_open afterwards
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      close_q  <= 1'b0;
      closed_q <= 1'b0;
    end else begin
      close_q <= 1'b0;
      if (!srv.conn_open) begin
        closed_q <= 1'b0;
      end else if (!closed_q && !srv.conn_request) begin
        if (!srv.server_en) begin
          close_q  <= 1'b1;
          closed_q <= 1'b1;
        end else if (srv.timeout_s != TIMEOUT_OFF && tick && idle_q >= srv.timeout_s) begin
          close_q  <= 1'b1;
          closed_q <= 1'b1;
        end
      end
    end
  end

  assign srv.conn_close = close_q;

endmodule // amc_conn_timer

// >>> sim/amc_host_model.sv
// Host application model: takes indications and responses, can stall
`timescale 1ns/1ps
module amc_host_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Stall control
  input  wire logic slow,
  // Handshakes
  input  wire logic ind_valid,
  output logic      ind_ready,
  input  wire logic rsp_valid,
  output logic      rsp_ready
);
  logic [1:0] phase_q;
  // Ready moves at the falling edge; a slow host agrees one cycle in three
  always @(negedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q   <= 2'h0;
      ind_ready <= 1'b0;
      rsp_ready <= 1'b0;
    end else begin
      phase_q   <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      // Indications are consumed only, never answered
      ind_ready <= !slow || phase_q == 2'h2;
      rsp_ready <= !slow || phase_q == 2'h1;
    end
  end
endmodule // amc_host_model

// >>> sim/amc_mailbox_chk.sv
// Port-level assertions for the mailbox block
`timescale 1ns/1ps
module amc_mailbox_chk #(
  parameter int unsigned TICKS_PER_SEC = 4
) (
  // Clock, reset, configuration
  input wire logic                           ref_clk,
  input wire logic                           reset_n,
  input wire logic                           init_done,
  // Indications
  input wire logic                           ind_valid,
  input wire logic                           ind_ready,
  input wire logic [15:0]                    ind_info,
  input wire logic [15:0]                    ind_size,
  input wire logic [amc_pkg::EXT_WORDS-1:0][15:0] ind_ext,
  // Commands and responses
  input wire logic                           cmd_valid,
  input wire logic                           cmd_ready,
  input wire logic [15:0]                    cmd_id,
  input wire logic [15:0]                    cmd_code,
  input wire logic [15:0]                    cmd_size,
  input wire logic [15:0]                    cmd_data,
  input wire logic                           rsp_valid,
  input wire logic [15:0]                    rsp_id,
  input wire logic [15:0]                    rsp_code,
  input wire logic [15:0]                    rsp_info,
  input wire logic [15:0]                    rsp_size,
  input wire logic [15:0]                    rsp_data,
  // Server
  input wire logic                           server_enable,
  input wire logic [15:0]                    timeout_value,
  input wire logic                           conn_close
);
  import amc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire take = cmd_valid && cmd_ready;

  property p_ind_hdr; ind_valid |-> ind_info == MSG_INFO_IND && ind_size == SIZE_NONE; endproperty
  a_ind_hdr: assert property (p_ind_hdr) else $error("indication header wrong");
  property p_ind_unused; ind_valid |-> ind_ext[EXT_WORDS-1:2] == '0; endproperty
  a_ind_unused: assert property (p_ind_unused) else $error("unused word not zero");
  property p_ind_reason; ind_valid |-> ind_ext[EXT_REASON_IDX] inside {[REASON_MIN:REASON_MAX]}; endproperty
  a_ind_reason: assert property (p_ind_reason) else $error("reason out of range");
  property p_ind_hold; ind_valid && !ind_ready |=> ind_valid && $stable(ind_ext); endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indication dropped early");
  property p_rsp; take |=> rsp_valid && rsp_code == $past(cmd_code) && rsp_id == $past(cmd_id); endproperty
  a_rsp: assert property (p_rsp) else $error("response late or mismatched");
  property p_busy; rsp_valid |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("command taken while response waits");
  property p_echo; take && cmd_code == CMD_CONN_TIMEOUT |=> rsp_data == $past(cmd_data); endproperty
  a_echo: assert property (p_echo) else $error("timeout word not echoed");
  property p_late; take && init_done |=> rsp_info == MSG_INFO_ERR && $stable(server_enable); endproperty
  a_late: assert property (p_late) else $error("late command applied");
  property p_dis;
    take && !init_done && cmd_code == CMD_SERVER_DISABLE && cmd_size == SIZE_NONE
      |=> !server_enable && rsp_info == MSG_INFO_RSP && rsp_size == SIZE_NONE;
  endproperty
  a_dis: assert property (p_dis) else $error("server disable not done");
  property p_off; timeout_value == TIMEOUT_OFF && server_enable |-> !conn_close; endproperty
  a_off: assert property (p_off) else $error("close with timeout off");

  c_ind: cover property (ind_valid && ind_ready);
  c_err: cover property (rsp_valid && rsp_info == MSG_INFO_ERR);
  c_close: cover property (conn_close);
endmodule // amc_mailbox_chk

bind amc_mailbox amc_mailbox_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .init_done(init_done), .ind_valid(ind_valid),
  .ind_ready(ind_ready), .ind_info(ind_info), .ind_size(ind_size), .ind_ext(ind_ext),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_code(cmd_code),
  .cmd_size(cmd_size), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_id(rsp_id),
  .rsp_code(rsp_code), .rsp_info(rsp_info), .rsp_size(rsp_size), .rsp_data(rsp_data),
  .server_enable(server_enable), .timeout_value(timeout_value), .conn_close(conn_close));

// >>> sim/amc_mailbox_tb.sv
// Self-checking bench for the mailbox block
`timescale 1ns/1ps
module amc_mailbox_tb;
  import amc_pkg::*;
  logic        ref_clk, reset_n, init_done, slow, ae, oe, cv, conn_open, conn_request;
  logic        ind_valid, ind_ready, cmd_ready, rsp_valid, rsp_ready, server_enable, conn_close;
  logic [15:0] adv, ah, ar, oh, orr, cid, ccode, csize, cdata, nid;
  logic [15:0] ind_id, ind_info, ind_cmd, ind_size, rsp_id, rsp_info, rsp_code, rsp_size;
  logic [15:0] rsp_data, timeout_value;
  logic [EXT_WORDS-1:0][15:0] ind_ext;
  int          failures, n_tests, cyc;

  amc_mailbox #(.TICKS_PER_SEC(4)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .advanced_mode_config_word(adv), .init_done(init_done),
    .abort_event(ae), .abort_handle(ah), .abort_reason(ar), .offline_event(oe),
    .offline_handle(oh), .offline_reason(orr), .ind_valid(ind_valid), .ind_ready(ind_ready),
    .ind_id(ind_id), .ind_info(ind_info), .ind_cmd(ind_cmd), .ind_size(ind_size), .ind_ext(ind_ext),
    .cmd_valid(cv), .cmd_ready(cmd_ready), .cmd_id(cid), .cmd_code(ccode), .cmd_size(csize),
    .cmd_data(cdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_id(rsp_id),
    .rsp_info(rsp_info), .rsp_code(rsp_code), .rsp_size(rsp_size), .rsp_data(rsp_data),
    .server_enable(server_enable), .timeout_value(timeout_value), .conn_open(conn_open),
    .conn_request(conn_request), .conn_close(conn_close));

  amc_host_model host (
    .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .ind_valid(ind_valid),
    .ind_ready(ind_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One command, driven for a single cycle, then the response is judged
  task automatic send_cmd(input logic [15:0] code, size, data, info, rsz, rdat);
    @(negedge ref_clk);
    cid   = cid + 16'h0001;
    ccode = code;
    csize = size;
    cdata = data;
    cv    = 1'b1;
    @(negedge ref_clk);
    cv = 1'b0;
    chk(rsp_valid, 1'b1);
    chk({rsp_id, rsp_code, rsp_info, rsp_size, rsp_data}, {cid, code, info, rsz, rdat});
    while (rsp_valid) @(negedge ref_clk);
  endtask

  // One event pulse; an indication is expected or must stay absent
  task automatic send_ev(input logic off, input logic [15:0] h, r, input logic want);
    @(negedge ref_clk);
    ah  = h;
    ar  = r;
    oh  = h;
    orr = r;
    ae  = !off;
    oe  = off;
    @(negedge ref_clk);
    ae = 1'b0;
    oe = 1'b0;
    for (int i = 0; i < 6 && !ind_valid; i++) @(negedge ref_clk);
    chk(ind_valid, want);
    if (want) begin
      chk({ind_id, ind_info, ind_size}, {nid, MSG_INFO_IND, SIZE_NONE});
      chk(ind_cmd, off ? CMD_REL_OFFLINE_IND : CMD_REL_ABORT_IND);
      chk(ind_ext, {96'h0, r, h});
      nid = nid + 16'h0001;
      while (ind_valid) @(negedge ref_clk);
    end
  endtask

  // Idle connection: cycles until the close pulse must fall within lo..hi; one request at req_at
  task automatic conn_watch(input int lo, input int hi, input int req_at);
    int n;
    n = 0;
    @(negedge ref_clk);
    conn_open = 1'b1;
    while (!conn_close && n < 200) begin
      conn_request = (n == req_at);
      @(negedge ref_clk);
      n++;
    end
    conn_request = 1'b0;
    conn_open    = 1'b0;
    chk(n >= lo && n <= hi, 1'b1);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out;
    end
  end

  initial begin
    {reset_n, init_done, slow, ae, oe, cv, conn_open, conn_request} = '0;
    {adv, ah, ar, oh, orr, cid, ccode, csize, cdata, nid} = '0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    chk({server_enable, timeout_value}, {1'b1, TIMEOUT_DEFAULT_S});
    send_ev(1'b0, 16'h0005, REASON_LINK_DOWN, 1'b0);
    adv = 16'h0001;
    send_ev(1'b0, 16'h1234, REASON_LINK_DOWN, 1'b1);
    slow = 1'b1;
    send_ev(1'b1, 16'hABCD, REASON_MIN, 1'b1);
    send_ev(1'b0, 16'h0007, REASON_MAX, 1'b1);
    send_ev(1'b1, 16'h0008, 16'h0021, 1'b0);
    send_ev(1'b0, 16'h0009, 16'h0002, 1'b0);
    send_cmd(CMD_CONN_TIMEOUT, SIZE_TIMEOUT, 16'h0009, MSG_INFO_ERR, SIZE_TIMEOUT, 16'h0009);
    chk(timeout_value, TIMEOUT_DEFAULT_S);
    send_cmd(CMD_CONN_TIMEOUT, SIZE_TIMEOUT, 16'hFFFF, MSG_INFO_RSP, SIZE_TIMEOUT, 16'hFFFF);
    chk(timeout_value, 16'hFFFF);
    send_cmd(CMD_CONN_TIMEOUT, SIZE_TIMEOUT, TIMEOUT_OFF, MSG_INFO_RSP, SIZE_TIMEOUT, TIMEOUT_OFF);
    conn_watch(200, 200, -1);
    send_cmd(CMD_CONN_TIMEOUT, SIZE_TIMEOUT, TIMEOUT_MIN_S, MSG_INFO_RSP, SIZE_TIMEOUT, TIMEOUT_MIN_S);
    conn_watch(41, 52, -1);
    conn_watch(61, 72, 20);
    send_cmd(CMD_SERVER_DISABLE, SIZE_TIMEOUT, 16'h0000, MSG_INFO_ERR, SIZE_NONE, 16'h0000);
    send_cmd(16'h0022, SIZE_NONE, 16'h0000, MSG_INFO_ERR, SIZE_NONE, 16'h0000);
    chk(server_enable, 1'b1);
    send_cmd(CMD_SERVER_DISABLE, SIZE_NONE, 16'h0000, MSG_INFO_RSP, SIZE_NONE, 16'h0000);
    chk(server_enable, 1'b0);
    conn_watch(0, 4, -1);
    init_done = 1'b1;
    send_cmd(CMD_CONN_TIMEOUT, SIZE_TIMEOUT, 16'h001E, MSG_INFO_ERR, SIZE_TIMEOUT, 16'h001E);
    chk(timeout_value, TIMEOUT_MIN_S);
    close_out;
  end
endmodule // amc_mailbox_tb
